// file: sbc_defs.vh
// constants for the system bus control register bank
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH
// register addresses in the cpu data space
`define SBC_ADDR_W          24
`define SBC_ADDR_BUSCFG     24'h00_ff00
`define SBC_ADDR_STACKPG    24'h00_ff01
`define SBC_ADDR_WAITCLK    24'h00_ff02
// bus configuration fields
`define SBC_BUS_EXP_BIT     7
`define SBC_CPU_SIZE_BIT    6
`define SBC_CE_TWO_BIT      2
`define SBC_CE_ZERO_BIT     0
`define SBC_RSV_HI_BIT      5
`define SBC_RSV_LO_BIT      3
// reset values of the stored bits
`define SBC_BUSCFG_RST_INT  8'h00
`define SBC_BUSCFG_RST_EXT  8'h01
`define SBC_STACKPG_RST     8'h00
`define SBC_WAITCLK_RST     8'h0c
// wait and clock fields
`define SBC_REL_EN_BIT      7
`define SBC_WAIT_HI_BIT     6
`define SBC_WAIT_LO_BIT     4
`define SBC_CLK_SRC_BIT     3
`define SBC_FOSC_RUN_BIT    2
// wait counter width
`define SBC_WCNT_W          4
// release sequencer states
`define SBC_REL_IDLE        2'h0
`define SBC_REL_FLOAT       2'h1
`define SBC_REL_GRANT       2'h2
`define SBC_REL_RESTORE     2'h3
`endif

// file: sbc_master.sv
// external bus master borrowing the bus by release handshake
module sbc_master (
    // clock and bench control
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [3:0] hold,
    // release handshake
    input  wire logic       ack,
    output logic            req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff;
    initial req_n = 1'b1;
    initial cnt_ff = 4'h0;
    always @(posedge mclk) begin
        if (req_n && go && ack) begin
            req_n <= 1'b0;
        end else if (!req_n && !ack) begin
            // request kept low until acknowledge, then for hold plus one cycles
            if (cnt_ff == hold) begin
                req_n <= 1'b1;
                cnt_ff <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule // sbc_master

// file: sbc_pin_mux.v
// shared port pin: chip enable or plain port output
module sbc_pin_mux (
    // selection
    input  wire ce_enable,
    input  wire expansion,
    input  wire bus_float,
    // sources
    input  wire ce_signal,
    input  wire port_data,
    // pin
    output wire pin_out,
    output wire pin_oe_n
);
    wire use_ce;

    assign use_ce   = ce_enable & expansion;
    assign pin_out  = use_ce ? ce_signal : port_data;
    assign pin_oe_n = use_ce & bus_float;
endmodule // sbc_pin_mux

// file: sbc_regs.v
// system bus control register bank
`include "sbc_defs.vh"
module sbc_regs (
    // clock and reset
    input  wire                   mclk,
    input  wire                   rst,
    // chip mode strap
    input  wire                   external_rom_chip_mode,
    // cpu register access
    input  wire [`SBC_ADDR_W-1:0] cpu_addr,
    input  wire [7:0]             cpu_wdata,
    input  wire                   cpu_wr,
    input  wire                   cpu_rd,
    output wire                   cpu_hit,
    output reg  [7:0]             cpu_rdata_ff,
    output reg                    cpu_done_ff,
    // external access wait stretch
    input  wire                   ext_access_start,
    output wire                   cpu_wait,
    // configuration outputs
    output wire                   bus_expansion_select,
    output wire                   cpu_size_select,
    output wire [7:0]             stack_page_bits,
    output wire [`SBC_WCNT_W-1:0] wait_count_field,
    output wire                   cpu_clock_source_select,
    output wire                   fast_oscillator_run,
    output wire                   bus_release_enable,
    // interrupt gating
    input  wire                   irq_in,
    input  wire                   nmi_in,
    output wire                   irq_out,
    output wire                   nmi_out,
    output wire                   int_unlocked,
    // chip enable and port pin sources
    input  wire [2:0]             ce_signal,
    input  wire [3:0]             port_data,
    // shared port pins
    output wire                   port_pin_zero,
    output wire                   port_pin_zero_oe_n,
    output wire                   port_pin_one,
    output wire                   port_pin_one_oe_n,
    output wire                   port_pin_two,
    output wire                   port_pin_two_oe_n,
    // bus release pins
    input  wire                   release_request_input_pin,
    output wire                   release_ack_output_pin,
    output wire                   release_ack_oe_n,
    output wire                   bus_float,
    output wire                   gen_port_input
);
    // strap and register state
    reg        ext_mode_ff;
    reg  [7:0] bus_cfg_ff;
    reg  [7:0] nxt_bus_cfg;
    reg  [7:0] stack_pg_ff;
    reg  [7:0] nxt_stack_pg;
    reg  [7:0] wait_clk_ff;
    reg  [7:0] nxt_wait_clk;
    reg        cfg_written_ff;
    reg        spg_written_ff;
    // read path
    reg  [7:0] nxt_rdata;
    reg  [7:0] bus_cfg_view;
    // release sequencer
    reg  [1:0] rel_state_ff;
    reg  [1:0] nxt_rel_state;
    reg        float_ff;
    reg        nxt_float;
    reg        ack_n_ff;
    reg        nxt_ack_n;
    // decode
    wire       hit_cfg;
    wire       hit_spg;
    wire       hit_wck;
    wire       wr_cfg;
    wire       wr_spg;
    wire       wr_wck;
    wire       expansion;
    wire       rel_request;
    wire       wait_busy;
    wire       wait_start;
    wire [2:0] ce_en;

    // address decode
    assign hit_cfg = cpu_addr == `SBC_ADDR_BUSCFG;
    assign hit_spg = cpu_addr == `SBC_ADDR_STACKPG;
    assign hit_wck = cpu_addr == `SBC_ADDR_WAITCLK;
    assign cpu_hit = hit_cfg | hit_spg | hit_wck;
    assign wr_cfg  = cpu_wr & hit_cfg;
    assign wr_spg  = cpu_wr & hit_spg;
    assign wr_wck  = cpu_wr & hit_wck;

    // strap caught by the clock while reset is held
    always @(posedge mclk) begin
        if (rst) begin
            ext_mode_ff <= external_rom_chip_mode;
        end
    end

    // bus configuration register
    always @* begin
        nxt_bus_cfg = bus_cfg_ff;
        if (wr_cfg) begin
            nxt_bus_cfg = cpu_wdata;
            if (ext_mode_ff) begin
                nxt_bus_cfg[`SBC_BUS_EXP_BIT] = 1'b0;
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            if (external_rom_chip_mode) begin
                bus_cfg_ff <= `SBC_BUSCFG_RST_EXT;
            end else begin
                bus_cfg_ff <= `SBC_BUSCFG_RST_INT;
            end
        end else begin
            bus_cfg_ff <= nxt_bus_cfg;
        end
    end

    // stack page register
    always @* begin
        nxt_stack_pg = stack_pg_ff;
        if (wr_spg) begin
            nxt_stack_pg = cpu_wdata;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            stack_pg_ff <= `SBC_STACKPG_RST;
        end else begin
            stack_pg_ff <= nxt_stack_pg;
        end
    end

    // wait and clock control register
    always @* begin
        nxt_wait_clk = wait_clk_ff;
        if (wr_wck) begin
            nxt_wait_clk = cpu_wdata;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            wait_clk_ff <= `SBC_WAITCLK_RST;
        end else begin
            wait_clk_ff <= nxt_wait_clk;
        end
    end

    // write tracking for the interrupt gate
    always @(posedge mclk) begin
        if (rst) begin
            cfg_written_ff <= 1'b0;
            spg_written_ff <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_written_ff <= 1'b1;
            end
            if (wr_spg) begin
                spg_written_ff <= 1'b1;
            end
        end
    end

    assign int_unlocked = cfg_written_ff & spg_written_ff;
    assign irq_out      = irq_in & int_unlocked;
    assign nmi_out      = nmi_in & int_unlocked;

    // read path
    always @* begin
        bus_cfg_view = bus_cfg_ff;
        if (ext_mode_ff) begin
            bus_cfg_view[`SBC_BUS_EXP_BIT] = 1'b1;
        end
    end

    always @* begin
        nxt_rdata = 8'h00;
        if (hit_cfg) begin
            nxt_rdata = bus_cfg_view;
        end else if (hit_spg) begin
            nxt_rdata = stack_pg_ff;
        end else if (hit_wck) begin
            nxt_rdata = wait_clk_ff;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            cpu_rdata_ff <= 8'h00;
            cpu_done_ff  <= 1'b0;
        end else begin
            cpu_done_ff <= cpu_rd | cpu_wr;
            if (cpu_rd) begin
                cpu_rdata_ff <= nxt_rdata;
            end
        end
    end

    // configuration outputs
    assign expansion = bus_cfg_view[`SBC_BUS_EXP_BIT];
    assign bus_expansion_select    = expansion;
    assign cpu_size_select         = bus_cfg_ff[`SBC_CPU_SIZE_BIT];
    assign stack_page_bits         = stack_pg_ff;
    assign cpu_clock_source_select = wait_clk_ff[`SBC_CLK_SRC_BIT];
    assign fast_oscillator_run     = wait_clk_ff[`SBC_FOSC_RUN_BIT];
    assign bus_release_enable      = wait_clk_ff[`SBC_REL_EN_BIT];
    // nonzero code n gives 2n states
    assign wait_count_field = {wait_clk_ff[`SBC_WAIT_HI_BIT:`SBC_WAIT_LO_BIT],
                               1'b0};

    // wait state stretcher
    assign wait_start = ext_access_start & ~float_ff; // no waits while released
    sbc_wait_gen u_wait (
        .mclk   (mclk),
        .rst    (rst),
        .start  (wait_start),
        .states (wait_count_field),
        .busy   (wait_busy)
    );

    assign cpu_wait = wait_busy | (wait_start &
                      (wait_count_field != {`SBC_WCNT_W{1'b0}}));

    // chip enable pins
    assign ce_en = bus_cfg_ff[`SBC_CE_TWO_BIT:`SBC_CE_ZERO_BIT];
    sbc_pin_mux u_pin_zero (
        .ce_enable (ce_en[0]),
        .expansion (expansion),
        .bus_float (float_ff),
        .ce_signal (ce_signal[0]),
        .port_data (port_data[0]),
        .pin_out   (port_pin_zero),
        .pin_oe_n  (port_pin_zero_oe_n)
    );

    sbc_pin_mux u_pin_one (
        .ce_enable (ce_en[1]),
        .expansion (expansion),
        .bus_float (float_ff),
        .ce_signal (ce_signal[1]),
        .port_data (port_data[1]),
        .pin_out   (port_pin_one),
        .pin_oe_n  (port_pin_one_oe_n)
    );

    sbc_pin_mux u_pin_two (
        .ce_enable (ce_en[2]),
        .expansion (expansion),
        .bus_float (float_ff),
        .ce_signal (ce_signal[2]),
        .port_data (port_data[2]),
        .pin_out   (port_pin_two),
        .pin_oe_n  (port_pin_two_oe_n)
    );

    // bus release sequencer
    assign rel_request = bus_release_enable &
                         ~release_request_input_pin;

    always @* begin
        nxt_rel_state = rel_state_ff;
        nxt_float     = float_ff;
        nxt_ack_n     = ack_n_ff;
        case (rel_state_ff)
            `SBC_REL_IDLE: begin
                if (rel_request & ~wait_busy) begin
                    nxt_rel_state = `SBC_REL_FLOAT;
                    nxt_float     = 1'b1;
                end
            end
            `SBC_REL_FLOAT: begin
                nxt_rel_state = `SBC_REL_GRANT;
                nxt_ack_n     = 1'b0;
            end
            `SBC_REL_GRANT: begin
                // the grant is held until the request goes high
                // dropping the enable also hands the bus back
                if (release_request_input_pin | ~bus_release_enable) begin
                    nxt_rel_state = `SBC_REL_RESTORE;
                    nxt_ack_n     = 1'b1;
                end
            end
            `SBC_REL_RESTORE: begin
                nxt_rel_state = `SBC_REL_IDLE;
                nxt_float     = 1'b0;
            end
            default: begin
                nxt_rel_state = `SBC_REL_IDLE;
                nxt_float     = 1'b0;
                nxt_ack_n     = 1'b1;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            rel_state_ff <= `SBC_REL_IDLE;
            float_ff     <= 1'b0;
            ack_n_ff     <= 1'b1;
        end else begin
            rel_state_ff <= nxt_rel_state;
            float_ff     <= nxt_float;
            ack_n_ff     <= nxt_ack_n;
        end
    end

    assign bus_float = float_ff;
    // acknowledge pin or plain port output
    assign release_ack_output_pin = bus_release_enable ? ack_n_ff
                                                       : port_data[3];
    assign release_ack_oe_n = 1'b0;
    assign gen_port_input   = release_request_input_pin;
endmodule // sbc_regs

// file: sbc_regs_properties.sv
// assertion checker for the bus control register bank
module sbc_chk (
    // clock, reset, strap
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        external_rom_chip_mode,
    // cpu access
    input wire logic [23:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic        cpu_done_ff,
    // wait and release
    input wire logic        ext_access_start,
    input wire logic        cpu_wait,
    input wire logic [3:0]  wait_count_field,
    input wire logic        bus_release_enable,
    input wire logic        release_request_input_pin,
    input wire logic        release_ack_output_pin,
    input wire logic        bus_float,
    // interrupts and pins
    input wire logic        irq_out,
    input wire logic        nmi_out,
    input wire logic        int_unlocked,
    input wire logic        bus_expansion_select,
    input wire logic [3:0]  port_data,
    input wire logic        port_pin_zero,
    input wire logic        port_pin_one,
    input wire logic        port_pin_two
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_int_blocked: assert property (!int_unlocked |-> !irq_out && !nmi_out)
        else $error("interrupt passed while locked");
    a_unlock_cause: assert property ($rose(int_unlocked) |->
        $past(cpu_wr) && $past(cpu_addr[23:1]) == 23'h7f_80)
        else $error("unlock without a write");
    a_unlock_hold: assert property (int_unlocked |=> int_unlocked)
        else $error("unlock flag dropped");
    a_done_pulse: assert property (cpu_rd || cpu_wr |=> cpu_done_ff)
        else $error("no done after access");
    a_ext_forced: assert property (external_rom_chip_mode |-> bus_expansion_select)
        else $error("external rom mode not expansion");
    a_wait_two: assert property (ext_access_start && !bus_float
        && wait_count_field == 4'h2 |-> cpu_wait ##1 cpu_wait [*2] ##1 !cpu_wait)
        else $error("wait length wrong");
    a_rel_grant: assert property (bus_release_enable && !bus_float
        && !release_request_input_pin && release_ack_output_pin && !cpu_wait
        |=> bus_float ##1 !release_ack_output_pin)
        else $error("release not granted");
    a_rel_end: assert property (bus_release_enable && bus_float
        && release_request_input_pin && !release_ack_output_pin
        |=> release_ack_output_pin ##1 !bus_float)
        else $error("release not ended");
    a_single_pins: assert property (!bus_expansion_select |->
        {port_pin_two, port_pin_one, port_pin_zero} == port_data[2:0])
        else $error("pins not port outputs");

    c_unlock: cover property ($rose(int_unlocked));
    c_float: cover property ($rose(bus_float));
    c_wait: cover property ($fell(cpu_wait));
endmodule // sbc_chk

bind sbc_regs sbc_chk u_sbc_chk (.mclk, .rst, .external_rom_chip_mode,
    .cpu_addr, .cpu_wr, .cpu_rd, .cpu_done_ff, .ext_access_start,
    .cpu_wait, .wait_count_field, .bus_release_enable,
    .release_request_input_pin, .release_ack_output_pin, .bus_float,
    .irq_out, .nmi_out, .int_unlocked, .bus_expansion_select, .port_data,
    .port_pin_zero, .port_pin_one, .port_pin_two);

// file: sbc_regs_tb.sv
// self-checking bench for the bus control register bank
module sbc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst, strap, wr, rd, xs, go, hit, done, wt, bx, csz;
    logic        clk_src, fo_run, rel_en, irq_o, nmi_o, unl, p0, p1, p2;
    logic        o0, o1, o2, req_n, ack, ack_oe_n, flt, irq_i, nmi_i, gpi;
    logic [23:0] addr;
    logic [7:0]  wdata, rdata, spb;
    logic [3:0]  pdat, wcnt;
    logic [2:0]  ce;
    int          n_errors, checks;
    int          cyc = 0;

    sbc_regs u_sbc_regs (.mclk(mclk), .rst(rst),
        .external_rom_chip_mode(strap), .cpu_addr(addr), .cpu_wdata(wdata),
        .cpu_wr(wr), .cpu_rd(rd), .cpu_hit(hit), .cpu_rdata_ff(rdata),
        .cpu_done_ff(done), .ext_access_start(xs), .cpu_wait(wt),
        .bus_expansion_select(bx), .cpu_size_select(csz),
        .stack_page_bits(spb), .wait_count_field(wcnt),
        .cpu_clock_source_select(clk_src), .fast_oscillator_run(fo_run),
        .bus_release_enable(rel_en), .irq_in(irq_i), .nmi_in(nmi_i),
        .irq_out(irq_o), .nmi_out(nmi_o), .int_unlocked(unl),
        .ce_signal(ce), .port_data(pdat), .port_pin_zero(p0),
        .port_pin_zero_oe_n(o0), .port_pin_one(p1), .port_pin_one_oe_n(o1),
        .port_pin_two(p2), .port_pin_two_oe_n(o2),
        .release_request_input_pin(req_n), .release_ack_output_pin(ack),
        .release_ack_oe_n(ack_oe_n), .bus_float(flt), .gen_port_input(gpi));
    sbc_master u_sbc_master (.mclk(mclk), .go(go), .hold(4'h3), .ack(ack),
        .req_n(req_n));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one register access, write when w is high
    task automatic acc(input logic [23:0] a, input logic [7:0] d,
                       input logic w);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge mclk);
        wr = 1'b0;
        rd = 1'b0;
    endtask

    task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp);
        acc(a, 8'h00, 1'b0);
        chk(rdata, exp);
        chk({7'h0, done}, 8'h01);
    endtask

    task automatic t_reset(input logic ext);
        @(negedge mclk);
        rst = 1'b1;
        strap = ext;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        rd_chk(24'h00_ff00, ext ? 8'h81 : 8'h00);
        rd_chk(24'h00_ff01, 8'h00);
        rd_chk(24'h00_ff02, 8'h0c);
        chk({5'h0, irq_o, nmi_o, unl}, 8'h00);
    endtask

    task automatic t_regs;
        acc(24'h00_ff00, 8'h7f, 1'b1);
        rd_chk(24'h00_ff00, 8'h7f);
        chk({6'h0, csz, bx}, 8'h02);
        chk({5'h0, p2, p1, p0}, {5'h0, pdat[2:0]});
        chk({7'h0, unl}, 8'h00);
        acc(24'h00_ff01, 8'h00, 1'b1);
        chk(spb, 8'h00);
        chk({6'h0, irq_o, unl}, 8'h03);
        irq_i = 1'b0;
        @(negedge mclk);
        chk({6'h0, irq_o, nmi_o}, 8'h01);
        irq_i = 1'b1;
        nmi_i = 1'b0;
        @(negedge mclk);
        chk({6'h0, irq_o, nmi_o}, 8'h02);
        nmi_i = 1'b1;
        acc(24'h00_ff00, 8'h85, 1'b1);
        rd_chk(24'h00_ff00, 8'h85);
        acc(24'h00_ff01, 8'h27, 1'b1);
        chk(spb, 8'h27);
        chk({5'h0, p2, p1, p0}, {5'h0, ce[2], pdat[1], ce[0]});
        chk({5'h0, o2, o1, o0}, 8'h00);
        acc(24'h00_ff03, 8'haa, 1'b1);
        rd_chk(24'h00_ff03, 8'h00);
        chk({7'h0, hit}, 8'h00);
        acc(24'h00_ff02, 8'h03, 1'b1);
        chk({6'h0, clk_src, fo_run}, 8'h00);
        rd_chk(24'h00_ff02, 8'h03);
    endtask

    task automatic t_wait;
        int n;
        for (int c = 0; c < 8; c++) begin
            acc(24'h00_ff02, {1'b0, c[2:0], 4'hc}, 1'b1);
            chk({4'h0, wcnt}, 8'(2 * c));
            @(negedge mclk);
            xs = 1'b1;
            @(negedge mclk);
            xs = 1'b0;
            n = 0;
            while (wt === 1'b1 && n < 20) begin
                n++;
                @(negedge mclk);
            end
            chk(8'(n), 8'(2 * c));
        end
    endtask

    task automatic t_release;
        int n;
        chk({7'h0, ack}, {7'h0, pdat[3]});
        acc(24'h00_ff02, 8'h8c, 1'b1);
        chk({7'h0, rel_en}, 8'h01);
        go = 1'b1;
        n = 0;
        while (flt !== 1'b1 && n < 10) begin
            n++;
            @(negedge mclk);
        end
        go = 1'b0;
        chk({5'h0, o2, o1, o0}, 8'h05);
        @(negedge mclk);
        chk({7'h0, ack}, 8'h00);
        while (flt !== 1'b0 && n < 30) begin
            n++;
            @(negedge mclk);
        end
        chk({6'h0, ack, flt}, 8'h02);
        chk({6'h0, ack_oe_n, gpi}, {7'h0, req_n});
    endtask

    task automatic t_ext;
        t_reset(1'b1);
        chk({5'h0, p2, p1, p0}, {5'h0, pdat[2:1], ce[0]});
        acc(24'h00_ff00, 8'h00, 1'b1);
        rd_chk(24'h00_ff00, 8'h80);
        chk({7'h0, bx}, 8'h01);
    endtask

    initial begin
        rst = 1'b1;
        strap = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        xs = 1'b0;
        go = 1'b0;
        irq_i = 1'b1;
        nmi_i = 1'b1;
        addr = 24'h00_0000;
        wdata = 8'h00;
        ce = 3'b101;
        pdat = 4'h2;
        n_errors = 0;
        checks = 0;
        t_reset(1'b0);
        t_regs;
        t_wait;
        t_release;
        t_ext;
        wrap_up;
    end
endmodule // sbc_regs_tb

// file: sbc_wait_gen.v
// wait state stretcher for external accesses
`include "sbc_defs.vh"
module sbc_wait_gen (
    // clock and reset
    input  wire                   mclk,
    input  wire                   rst,
    // control
    input  wire                   start,
    input  wire [`SBC_WCNT_W-1:0] states,
    // status
    output wire                   busy
);
    reg  [`SBC_WCNT_W-1:0] count_ff;
    reg  [`SBC_WCNT_W-1:0] nxt_count;

    always @* begin
        nxt_count = count_ff;
        if (start) begin
            nxt_count = states;
        end else if (count_ff != {`SBC_WCNT_W{1'b0}}) begin
            nxt_count = count_ff - {{(`SBC_WCNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            count_ff <= {`SBC_WCNT_W{1'b0}};
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign busy = count_ff != {`SBC_WCNT_W{1'b0}};
endmodule // sbc_wait_gen
